// ### inc/acq_defs.svh
/*
   Register offsets, field positions, reset values and timing counts of the
   acquisition trigger control block. Assumes a 50 MHz system clock.
*/
// Summary of operation
// R1 - Sixteen channels convert together and results stream into FIFO.
// R2 - Host start runs at once; armed trigger event also starts.
// R3 - Host stop ends a run; a trigger ends it if trigger-stop set.
// R4 - A programmed sample count ends the run by itself.
// R5 - Single mode: each trigger makes exactly one measurement on all cards.
// R6 - Edge mode: one edge starts, next edge stops; polarity selectable.
// R7 - Gate mode: acquire only while trigger at active level; level selectable.
// R8 - Scan count defaults to unlimited; then second trigger stops.
// R9 - Limited scans: later trigger restarts a fresh set once previous done.
// R10 - Limited scans: trigger before set complete sets the error flag.
// R11 - No error once last scan began; such trigger restarts acquisition.
// R12 - One microsecond hold-off follows every start or stop trigger.
// R13 - Triggers inside hold-off are dropped without any error.
// R14 - Trigger source: software, front panel input or carrier line.
// R15 - One output rate for all channels, capped at variant maximum.
// R16 - Sample clock from onboard synthesizer or external line.
// R17 - Synthesizer resolution finer than 1 Hz, shareable across cards.
// R18 - Further decimation allows output rates down to 1 sample/s.
// R19 - Card is master or slave; a lone card is master.
// R20 - Master drives clock and sync lines to every slave.
// R21 - Per-channel gain chosen by software from eleven factors.
// R22 - Per-channel selector picks input or shared reference bus.
// R23 - Early-trigger error stays set until software clears it.
`ifndef ACQ_DEFS_SVH
`define ACQ_DEFS_SVH
`define A_CTRL     8'h00
`define A_CMD      8'h04
`define A_STAT     8'h08
`define A_SCANS    8'h0C
`define A_DDS      8'h10
`define A_DECIM    8'h14
`define A_GLO      8'h18
`define A_GHI      8'h1C
`define A_CAL      8'h20
`define A_CHEN     8'h24
`define A_COUNT    8'h28
`define F_MODE     1:0
`define F_SRC      3:2
`define F_POL      4
`define F_CKEXT    5
`define F_MASTER   6
`define F_TSTOP    7
`define F_SWGATE   8
`define C_START    0
`define C_STOP     1
`define C_ARM      2
`define C_SW       3
`define CTRL_RST   32'h0000_00D0
`define CHEN_RST   16'hFFFF
`define GAIN_MAX   4'hA
`define CLK_HZ     50000000
`define MAX_RATE_HZ 10000
`define HOLDOFF_NS 1000
`define HOLDOFF_CYC ((`HOLDOFF_NS * (`CLK_HZ / 1000000)) / 1000)
`endif

// ### inc/acq_pkg.sv
/*
   Types shared by the acquisition trigger control block and its bench.
   Assumes acq_defs.svh supplies the numeric constants.
*/
package acq_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} acq_state_e;
   typedef enum logic [1:0] {M_EDGE, M_GATE, M_SCAN, M_SINGLE} trig_mode_e;
   typedef struct packed {
      logic [15:0][23:0] ch;
   } adc_word_s;
   typedef struct packed {
      logic [15:0]       en;
      logic [15:0][23:0] ch;
   } fifo_word_s;
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } axil_req_s;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_s;
endpackage

// ### logic/acq_trigger_ctrl.sv
/*
   Acquisition trigger control with AXI4-Lite register access, trigger
   qualification, sample clock generation and multi-card sync.
   Assumes the converters answer convert_start with adc_valid and that
   pins arrive unsynchronised.
*/
`timescale 1ns/100ps
`include "acq_defs.svh"
module acq_trigger_ctrl #(
   parameter int unsigned MIN_GAP = `CLK_HZ / `MAX_RATE_HZ
) (
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire acq_pkg::axil_req_s axi,
   output acq_pkg::axil_rsp_s      axo,
   input  wire logic               trig_front_n,
   input  wire logic               trig_carrier_n,
   input  wire logic               ext_clk,
   input  wire logic               sclk_i,
   output logic                    sclk_o,
   output logic                    sclk_oe,
   input  wire logic               sync_i,
   output logic                    sync_o,
   output logic                    sync_oe,
   output logic                    convert_start,
   input  wire logic               adc_valid,
   input  wire acq_pkg::adc_word_s adc_data,
   input  wire logic               fifo_full,
   output logic                    fifo_wr,
   output acq_pkg::fifo_word_s     fifo_data,
   output logic [63:0]             gain_sel,
   output logic [15:0]             ref_sel
);
   import acq_pkg::*;

   localparam logic [5:0] HOLD_CYC = 6'(`HOLDOFF_CYC);
   localparam int unsigned GW = $clog2(MIN_GAP + 1);
   localparam logic [GW-1:0] GAP_MAX = GW'(MIN_GAP);

   logic [31:0]   ctrl;
   logic [31:0]   scans;
   logic [31:0]   dds_inc;
   logic [15:0]   decim;
   logic [15:0]   chen;
   logic [31:0]   cnt;
   logic          aw_full;
   logic          w_full;
   logic [7:0]    waddr;
   logic [31:0]   wdat;
   logic [3:0]    wstb;
   logic [4:0]    s1;
   logic [4:0]    s2;
   logic [4:0]    s3;
   logic [4:0]    pin;
   logic [4:0]    pin_d;
   logic          lvl_d;
   logic [5:0]    hold;
   logic [31:0]   acc;
   logic          dds_c;
   logic [15:0]   dcnt;
   logic [GW-1:0] gap;
   logic          err;
   logic          ovf;
   acq_state_e    state;
   acq_state_e    next_state;
   logic          restart;
   logic          go_hold;
   logic          err_set;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Codes above the top factor would select no gain stage, so they clamp.
   function automatic logic [31:0] clamp(input logic [31:0] v);
      logic [31:0] r;
      r = v;
      for (int i = 0; i < 8; i++) begin
         if (v[4*i +: 4] > `GAIN_MAX) begin
            r[4*i +: 4] = `GAIN_MAX;
         end
      end
      return r;
   endfunction

   wire aw_hs  = axi.awvalid & axo.awready;
   wire w_hs   = axi.wvalid & axo.wready;
   wire wr_go  = aw_full & w_full & ~axo.bvalid;
   wire rd_hs  = axi.arvalid & axo.arready;
   wire [7:0] ra = axi.araddr;

   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= `A_COUNT;
   endfunction

   wire hit_ctrl  = wr_go & (waddr == `A_CTRL);
   wire hit_cmd   = wr_go & (waddr == `A_CMD) & wstb[0];
   wire hit_stat  = wr_go & (waddr == `A_STAT) & wstb[0];
   wire hit_scans = wr_go & (waddr == `A_SCANS);
   wire hit_dds   = wr_go & (waddr == `A_DDS);
   wire hit_decim = wr_go & (waddr == `A_DECIM);
   wire hit_glo   = wr_go & (waddr == `A_GLO);
   wire hit_ghi   = wr_go & (waddr == `A_GHI);
   wire hit_cal   = wr_go & (waddr == `A_CAL);
   wire hit_chen  = wr_go & (waddr == `A_CHEN);
   wire [3:0] cmd = hit_cmd ? wdat[3:0] : 4'h0;
   wire err_clr   = hit_stat & wdat[2];
   wire ovf_clr   = hit_stat & wdat[3];

   wire [4:0] stat = {hold != 6'h00, ovf, err, state == ST_ARMED,
                      state == ST_RUN};
   wire [31:0] rd_val =
      (ra == `A_CTRL)  ? ctrl :
      (ra == `A_STAT)  ? {27'h0, stat} :
      (ra == `A_SCANS) ? scans :
      (ra == `A_DDS)   ? dds_inc :
      (ra == `A_DECIM) ? {16'h0, decim} :
      (ra == `A_GLO)   ? gain_sel[31:0] :
      (ra == `A_GHI)   ? gain_sel[63:32] :
      (ra == `A_CAL)   ? {16'h0, ref_sel} :
      (ra == `A_CHEN)  ? {16'h0, chen} :
      (ra == `A_COUNT) ? cnt : 32'h0;

   // Address and data are captured independently; the write lands once both
   // are held, so the master may present them in either order.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         axo     <= '0;
         aw_full <= 1'b0;
         w_full  <= 1'b0;
         waddr   <= 8'h00;
         wdat    <= 32'h0;
         wstb    <= 4'h0;
         axo.awready <= 1'b1;
         axo.wready  <= 1'b1;
         axo.arready <= 1'b1;
      end else begin
         if (aw_hs) begin
            aw_full     <= 1'b1;
            waddr       <= axi.awaddr;
            axo.awready <= 1'b0;
         end
         if (w_hs) begin
            w_full     <= 1'b1;
            wdat       <= axi.wdata;
            wstb       <= axi.wstrb;
            axo.wready <= 1'b0;
         end
         if (wr_go) begin
            aw_full    <= 1'b0;
            w_full     <= 1'b0;
            axo.bvalid <= 1'b1;
            axo.bresp  <= mapped(waddr) ? 2'h0 : 2'h2;
         end
         if (axo.bvalid & axi.bready) begin
            axo.bvalid  <= 1'b0;
            axo.awready <= 1'b1;
            axo.wready  <= 1'b1;
         end
         if (rd_hs) begin
            axo.arready <= 1'b0;
            axo.rvalid  <= 1'b1;
            axo.rdata   <= rd_val;
            axo.rresp   <= mapped(ra) ? 2'h0 : 2'h2;
         end
         if (axo.rvalid & axi.rready) begin
            axo.rvalid  <= 1'b0;
            axo.arready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl     <= `CTRL_RST; // R19
         scans    <= 32'h0; // R8
         dds_inc  <= 32'h0;
         decim    <= 16'h0;
         chen     <= `CHEN_RST;
         gain_sel <= 64'h0;
         ref_sel  <= 16'h0;
      end else begin
         if (hit_ctrl) ctrl <= merge(ctrl, wdat, wstb);
         if (hit_scans) scans <= merge(scans, wdat, wstb);
         if (hit_dds) dds_inc <= merge(dds_inc, wdat, wstb); // R17
         if (hit_decim) decim <= 16'(merge({16'h0, decim}, wdat, wstb));
         if (hit_chen) chen <= 16'(merge({16'h0, chen}, wdat, wstb));
         if (hit_glo) gain_sel[31:0] <= clamp(merge(gain_sel[31:0], wdat, wstb)); // R21
         if (hit_ghi) gain_sel[63:32] <= clamp(merge(gain_sel[63:32], wdat, wstb)); // R21
         if (hit_cal) ref_sel <= 16'(merge({16'h0, ref_sel}, wdat, wstb)); // R22
      end
   end

   // Pins pass three stages; a new level counts only when the last two agree.
   wire [4:0] raw = {sync_i, sclk_i, ext_clk, ~trig_carrier_n, ~trig_front_n};
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s1    <= 5'h00;
         s2    <= 5'h00;
         s3    <= 5'h00;
         pin   <= 5'h00;
         pin_d <= 5'h00;
      end else begin
         s1    <= raw;
         s2    <= s1;
         s3    <= s2;
         pin   <= (s2 & s3) | (pin & (s2 ^ s3));
         pin_d <= pin;
      end
   end

   wire        master   = ctrl[`F_MASTER];
   wire [1:0]  src      = ctrl[`F_SRC];
   trig_mode_e mode;
   assign mode = trig_mode_e'(ctrl[`F_MODE]);
   wire lvl_raw = (src == 2'h1) ? pin[0] : // R14
                  (src == 2'h2) ? pin[1] : ctrl[`F_SWGATE];
   wire lvl      = lvl_raw ~^ ctrl[`F_POL]; // R6 R7
   wire hold_act = hold != 6'h00;
   wire ev_raw   = (lvl & ~lvl_d) | ((src == 2'h0) & cmd[`C_SW]);
   wire ev       = ev_raw & ~hold_act; // R13
   wire lim      = scans != 32'h0; // R8
   wire last     = cnt == scans;
   wire run_ok   = ~lim | (cnt < scans); // R4
   wire single_ev = master & (mode == M_SINGLE) & (state == ST_ARMED) & ev; // R5

   // The accumulator width gives 50 MHz / 2^32, well under 1 Hz per step.
   wire [32:0] acc_n    = {1'b0, acc} + {1'b0, dds_inc}; // R17
   wire        ext_rise = pin[2] & ~pin_d[2];
   wire        base_tick = ~master ? (pin[3] ^ pin_d[3]) : // R19
                           ctrl[`F_CKEXT] ? ext_rise : dds_c; // R16
   wire        dec_tick = base_tick & (dcnt >= decim); // R18
   wire        out_tick = dec_tick & (gap == GAP_MAX); // R15
   wire        conv = master ?
      (((state == ST_RUN) & out_tick & run_ok) | single_ev) :
      (pin[4] & base_tick); // R1 R20

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         acc   <= 32'h0;
         dds_c <= 1'b0;
         dcnt  <= 16'h0;
         gap   <= GAP_MAX;
         lvl_d <= 1'b0;
      end else begin
         lvl_d <= lvl;
         acc   <= acc_n[31:0];
         dds_c <= acc_n[32];
         if (dec_tick) dcnt <= 16'h0;
         else if (base_tick) dcnt <= dcnt + 16'h1;
         // A tick closer than the rate ceiling allows is dropped. R15
         if (out_tick) gap <= '0;
         else if (gap != GAP_MAX) gap <= gap + 1'b1;
      end
   end

   always_comb begin
      next_state = state;
      restart    = 1'b0;
      go_hold    = 1'b0;
      err_set    = 1'b0;
      case (state)
         ST_IDLE: begin
            if (cmd[`C_START]) begin
               next_state = ST_RUN; // R2
               restart    = 1'b1;
            end else if (cmd[`C_ARM]) begin
               next_state = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (cmd[`C_START]) begin
               next_state = ST_RUN;
               restart    = 1'b1;
            end else if (cmd[`C_STOP]) begin
               next_state = ST_IDLE;
            end else if (mode == M_GATE) begin
               if (lvl & ~hold_act) begin
                  next_state = ST_RUN; // R7
                  restart    = 1'b1;
                  go_hold    = 1'b1; // R12
               end
            end else if (ev) begin
               go_hold = 1'b1; // R12
               if (mode != M_SINGLE) begin
                  next_state = ST_RUN; // R2 R6 R9
                  restart    = 1'b1;
               end
            end
         end
         ST_RUN: begin
            if (cmd[`C_STOP]) begin
               next_state = ST_IDLE; // R3
            end else if (mode == M_GATE) begin
               if (~lvl & ~hold_act) begin
                  next_state = ST_ARMED; // R7
                  go_hold    = 1'b1;
               end
            end else if (ev & (mode == M_SCAN) & lim) begin
               if (last) begin
                  restart = 1'b1; // R11
                  go_hold = 1'b1;
               end else begin
                  err_set = 1'b1; // R10
               end
            end else if (ev & ctrl[`F_TSTOP]) begin
               next_state = ST_IDLE; // R3 R6 R8
               go_hold    = 1'b1;
            end else if (lim & last & adc_valid) begin
               next_state = (mode == M_SCAN) ? ST_ARMED : ST_IDLE; // R4 R9
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         hold  <= 6'h00;
         cnt   <= 32'h0;
         err   <= 1'b0;
         ovf   <= 1'b0;
      end else begin
         state <= master ? next_state : ST_IDLE;
         if (go_hold) hold <= HOLD_CYC; // R12
         else if (hold_act) hold <= hold - 6'h01;
         if (restart) cnt <= 32'h0;
         else if (conv) cnt <= cnt + 32'h1;
         // A new event in the clearing cycle wins over the clear.
         err <= err_set | (err & ~err_clr); // R10 R23
         ovf <= (adc_valid & fifo_full) | (ovf & ~ovf_clr);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         convert_start <= 1'b0;
         fifo_wr       <= 1'b0;
         fifo_data     <= '0;
         sclk_o        <= 1'b0;
         sclk_oe       <= 1'b0;
         sync_o        <= 1'b0;
         sync_oe       <= 1'b0;
      end else begin
         convert_start <= conv; // R1
         fifo_wr       <= adc_valid & ~fifo_full; // R1
         fifo_data     <= {chen, adc_data};
         // Slaves count every change of the shared clock while sync is high as one sample.
         if (conv & master) sclk_o <= ~sclk_o; // R20
         sclk_oe <= master; // R19 R20
         sync_oe <= master;
         sync_o  <= (next_state == ST_RUN) | single_ev |
                    ((mode == M_SINGLE) & hold_act); // R5 R20
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_hold_win;
      hold_act ##49 hold_act ##1 !hold_act;
   endsequence

   AST_HOLD_LEN: assert property (go_hold |=> s_hold_win) // R12
      else $error("hold-off window length wrong");
   AST_HOLD_QUIET: assert property (hold_act && mode != M_GATE |-> !go_hold && !err_set) // R13
      else $error("trigger acted inside hold-off");
   AST_ERR_SET: assert property (err_set |=> err) // R10
      else $error("early trigger did not flag");
   AST_ERR_STICK: assert property (err && !err_clr |=> err) // R23
      else $error("error flag dropped without clear");
   AST_START: assert property (master && state == ST_IDLE && cmd[`C_START]
                               |=> state == ST_RUN && cnt == 32'h0) // R2
      else $error("start command did not run");
   AST_STOP: assert property (state == ST_RUN && cmd[`C_STOP] |=> state == ST_IDLE) // R3
      else $error("stop command ignored");
   AST_LIMIT: assert property (state == ST_RUN && lim |-> cnt <= scans) // R4
      else $error("more scans than programmed");
   AST_SINGLE: assert property (single_ev |=> convert_start ##1 $stable(state)) // R5
      else $error("single trigger gave no conversion");
   AST_RETRIG: assert property (state == ST_RUN && mode == M_SCAN && lim && last && ev
                                && !cmd[`C_STOP] |=> state == ST_RUN && !err_set) // R11
      else $error("retrigger on last scan failed");
   AST_FIFO: assert property (fifo_wr |-> $past(adc_valid)) // R1
      else $error("fifo write without data");
endmodule

// ### testbench/adc_model.sv
/*
   Behavioural model of the sixteen converters behind the trigger control.
   Assumes convert_start is a one-cycle pulse taken on the rising clock edge.
*/
`timescale 1ns/100ps
module adc_model #(
   parameter int LAT = 3
) (
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire logic          convert_start,
   output logic               adc_valid,
   output acq_pkg::adc_word_s adc_data
);
   import acq_pkg::*;
   logic [7:0] seq;
   logic [3:0] wait_cnt;
   // One start converts all channels at once and they answer in one word.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         seq <= 8'h00;
         wait_cnt <= 4'h0;
         adc_valid <= 1'b0;
         adc_data <= '0;
      end else begin
         adc_valid <= (wait_cnt == 4'h1);
         seq <= seq + 8'((wait_cnt == 4'h1));
         if (convert_start) begin
            wait_cnt <= 4'(LAT);
         end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
         end
         for (int i = 0; i < 16; i++) begin
            // Data is not held once the valid cycle is over.
            adc_data.ch[i] <= (wait_cnt == 4'h1) ? {seq, 16'(i)} : ~adc_data.ch[i];
         end
      end
   end
endmodule

// ### testbench/testbench.sv
/*
   Self-checking bench for the acquisition trigger control.
   Assumes the converter model and the design's register map constants.
*/
`timescale 1ns/100ps
`include "acq_defs.svh"
module testbench;
   import acq_pkg::*;
   logic        clock, rst, trig_front_n, fifo_full, convert_start, adc_valid, fifo_wr;
   logic        sclk_o, sclk_oe, sync_o, sync_oe, sclk_i, sync_i, ext_clk, trig_carrier_n;
   axil_req_s   req;
   axil_rsp_s   rsp;
   adc_word_s   adc_data;
   fifo_word_s  fifo_data;
   logic [63:0] gain_sel, ge, g;
   logic [15:0] ref_sel, chen;
   logic [31:0] r;
   int          error_cnt, samples_checked, cyc, wr_cnt, base;
   logic [33:0] rq[$];
   logic [31:0] rmask[$];
   fifo_word_s  fq[$];

   acq_trigger_ctrl #(.MIN_GAP(8)) dut (
      .clock(clock), .rst(rst), .axi(req), .axo(rsp),
      .trig_front_n(trig_front_n), .trig_carrier_n(trig_carrier_n), .ext_clk(ext_clk),
      .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .sync_i(sync_i),
      .sync_o(sync_o), .sync_oe(sync_oe), .convert_start(convert_start),
      .adc_valid(adc_valid), .adc_data(adc_data), .fifo_full(fifo_full),
      .fifo_wr(fifo_wr), .fifo_data(fifo_data), .gain_sel(gain_sel), .ref_sel(ref_sel));
   adc_model model (.clock(clock), .rst(rst), .convert_start(convert_start),
      .adc_valid(adc_valid), .adc_data(adc_data));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic miss(input logic [63:0] got, input logic [63:0] exp);
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
   endtask
   task automatic chk_reg(input logic [33:0] got, input logic [33:0] exp);
      samples_checked++;
      if (got !== exp) miss(64'(got), 64'(exp));
   endtask
   task automatic chk_out(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) miss(got, exp);
   endtask
   task automatic chk_fifo(input fifo_word_s got, input fifo_word_s exp);
      samples_checked++;
      if (got !== exp) miss(64'(got), 64'(exp));
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         conclude();
      end
   end

   // Results are compared where they are settled, half a cycle before the taking edge.
   always @(negedge clock) begin
      if (rsp.rvalid && req.rready) chk_reg({rsp.rresp, rsp.rdata & rmask.pop_front()},
                                            rq.pop_front());
      if (adc_valid && !fifo_full) fq.push_back({chen, adc_data});
      if (fifo_wr) begin
         wr_cnt++;
         if (fq.size() == 0) miss(64'h1, 64'h0);
         else chk_fifo(fifo_data, fq.pop_front());
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      b = 1'b0;
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      while (!b) begin
         @(negedge clock);
         aw = req.awvalid & rsp.awready;
         w = req.wvalid & rsp.wready;
         b = req.bready & rsp.bvalid;
         @(posedge clock);
         if (aw) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
         if (b) req.bready <= 1'b0;
      end
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [31:0] m);
      logic ar, rr;
      rr = 1'b0;
      rq.push_back(e);
      rmask.push_back(m);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      while (!rr) begin
         @(negedge clock);
         ar = req.arvalid & rsp.arready;
         rr = req.rready & rsp.rvalid;
         @(posedge clock);
         if (ar) req.arvalid <= 1'b0;
         if (rr) req.rready <= 1'b0;
      end
      @(posedge clock);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wait_wr(input int n);
      int k;
      k = 0;
      while (wr_cnt < n && k < 5000) begin
         @(posedge clock);
         k++;
      end
   endtask
   task automatic pulse(input int n);
      trig_front_n <= 1'b0;
      idle(n);
      trig_front_n <= 1'b1;
      idle(70);
   endtask
   task automatic clk_run(input int n);
      repeat (n) begin
         idle(20);
         sclk_i <= ~sclk_i;
         ext_clk <= ~ext_clk;
      end
      idle(20);
   endtask

   initial begin
      req = '0;
      rst = 1'b1;
      trig_front_n = 1'b1;
      trig_carrier_n = 1'b1;
      {sclk_i, sync_i, ext_clk} = 3'h0;
      fifo_full = 1'b0;
      chen = `CHEN_RST;
      r = $urandom(32'h576ae056);
      idle(4);
      rst <= 1'b0;
      idle(1);
      rd(`A_CTRL, 34'(`CTRL_RST), 32'hFFFF_FFFF);
      rd(`A_CHEN, 34'(`CHEN_RST), 32'hFFFF_FFFF);
      rd(8'h2C, {2'h2, 32'h0}, 32'hFFFF_FFFF);
      chk_out(64'({sclk_oe, sync_oe}), 64'h3);
      g = {$urandom, $urandom};
      r = $urandom;
      wr(`A_GLO, g[31:0]);
      wr(`A_GHI, g[63:32]);
      wr(`A_CAL, r);
      for (int i = 0; i < 16; i++) ge[i*4+:4] = (g[i*4+:4] > `GAIN_MAX) ? `GAIN_MAX : g[i*4+:4];
      chk_out(gain_sel, ge);
      chk_out(64'(ref_sel), 64'(r[15:0]));
      chen = 16'($urandom);
      wr(`A_CHEN, 32'(chen));
      wr(`A_DDS, 32'h0CCC_CCCD);
      wr(`A_DECIM, 32'h0);
      // Host start, stream, a full FIFO, then host stop.
      wr(`A_CMD, 32'h1);
      rd(`A_STAT, 34'h1, 32'h1);
      chk_out(64'(sync_o), 64'h1);
      wait_wr(wr_cnt + 4);
      fifo_full <= 1'b1;
      idle(60);
      fifo_full <= 1'b0;
      rd(`A_STAT, 34'h8, 32'h8);
      wr(`A_CMD, 32'h2);
      rd(`A_STAT, 34'h0, 32'h1);
      // Counted scans from software triggers, one sample every ten ticks.
      wr(`A_CTRL, 32'hD2);
      wr(`A_SCANS, 32'h3);
      wr(`A_DECIM, 32'h9);
      wr(`A_CMD, 32'h4);
      base = wr_cnt;
      wr(`A_CMD, 32'h8);
      rd(`A_STAT, 34'h11, 32'h13);
      wr(`A_CMD, 32'h8);
      rd(`A_STAT, 34'h0, 32'h4);
      idle(60);
      rd(`A_STAT, 34'h0, 32'h10);
      wr(`A_CMD, 32'h8);
      rd(`A_STAT, 34'h5, 32'h5);
      idle(100);
      rd(`A_STAT, 34'h4, 32'h4);
      wr(`A_STAT, 32'h4);
      rd(`A_STAT, 34'h0, 32'h4);
      wait_wr(base + 2);
      while (!convert_start) @(negedge clock);
      @(posedge clock);
      wr(`A_CMD, 32'h8);
      rd(`A_STAT, 34'h1, 32'h5);
      wait_wr(base + 6);
      idle(5);
      rd(`A_STAT, 34'h2, 32'h3);
      // Edge mode from the front-panel pin, gate mode from the carrier line.
      wr(`A_CTRL, 32'hD4);
      wr(`A_SCANS, 32'h0);
      wr(`A_CMD, 32'h4);
      for (int k = 0; k < 2; k++) begin
         pulse($urandom_range(20, 5));
         rd(`A_STAT, 34'(k == 0), 32'h1);
      end
      wr(`A_CTRL, 32'hD9);
      wr(`A_CMD, 32'h4);
      trig_carrier_n <= 1'b0;
      idle(70);
      rd(`A_STAT, 34'h1, 32'h1);
      trig_carrier_n <= 1'b1;
      idle(70);
      rd(`A_STAT, 34'h0, 32'h1);
      // Single measurement: one trigger, exactly one conversion, still armed.
      wr(`A_CTRL, 32'hD3);
      wr(`A_CMD, 32'h4);
      base = wr_cnt;
      wr(`A_CMD, 32'h8);
      idle(20);
      rd(`A_STAT, 34'h12, 32'h13);
      chk_out(64'(wr_cnt - base), 64'h1);
      // Slave: one conversion per change of the shared clock while sync is high.
      wr(`A_CTRL, 32'h90);
      base = wr_cnt;
      sync_i <= 1'b1;
      clk_run(6);
      sync_i <= 1'b0;
      chk_out(64'(wr_cnt - base), 64'h6);
      chk_out(64'({sclk_oe, sync_oe}), 64'h0);
      // External sample clock: one conversion per rising edge.
      wr(`A_CTRL, 32'hF0);
      wr(`A_DECIM, 32'h0);
      wr(`A_CMD, 32'h1);
      base = wr_cnt;
      clk_run(6);
      wr(`A_CMD, 32'h2);
      chk_out(64'(wr_cnt - base), 64'h3);
      idle(5);
      conclude();
   end
endmodule
